// *** supply_monitor.sv ***
/*
 * Supply monitor: control register, status flag, delayed interrupt request, IDLE wake-up,
 * reached over APB.
 * Assumes an analog comparator that reports supply below the selected trip level, and a
 * power controller that reports IDLE and SLEEP and takes a wake request.
 */
`timescale 1ns/1ps
`include "supply_monitor_regs.svh"
module supply_monitor
    import supply_monitor_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        comparator_below,
    input  wire logic        idle_mode,
    input  wire logic        sleep_mode,
    output logic             detector_power,
    output logic [2:0]       trip_level_code,
    output logic             multi_source_irq_pending,
    output logic             cpu_irq,
    output logic             idle_wake,
    output logic             event_irq
);

    // ======================================================================
    // state
    low_voltage_ctrl_t ctrl;
    irq_bits_t         irq_bits;
    logic              global_irq_enable;
    logic [`EVT_WIDTH-1:0] evt_status;
    logic [`EVT_WIDTH-1:0] evt_mask;
    logic              below_sync;
    logic              flag_prev;
    logic              delay_run;
    logic [`DELAY_CNT_W-1:0] delay_cnt;
    logic              irq_prev;
    logic              detector_active;
    logic              delay_done;
    logic              wr_en;
    logic              rd_en;
    logic              low_byte_wr;
    logic [`EVT_WIDTH-1:0] next_evt_status;
    logic [`EVT_WIDTH-1:0] evt_set;

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = addr_hit(a, `OFS_LOW_VOLTAGE_CONTROL) | addr_hit(a, `OFS_MULTI_SOURCE_IRQ_B)
                    | addr_hit(a, `OFS_GLOBAL_IRQ) | addr_hit(a, `OFS_EVENT_STATUS)
                    | addr_hit(a, `OFS_EVENT_MASK);
    endfunction

    // ======================================================================
    // comparator crossing
    bit_sync u_below_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (comparator_below),
        .sync_out (below_sync)
    );

    // ======================================================================
    // detector power
    assign detector_active = ctrl.detector_on & ~sleep_mode;
    assign detector_power  = detector_active;
    assign trip_level_code = ctrl.trip_level_select;

    // ======================================================================
    // apb decode; zero wait states, so access phase ends in one cycle
    assign pready      = 1'b1;
    assign wr_en       = psel & penable & pwrite;
    assign rd_en       = psel & ~penable & ~pwrite;
    assign low_byte_wr = wr_en & pstrb[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & ~penable & ~addr_mapped(paddr);
        end
    end

    // ======================================================================
    // control register: status flag follows the comparator only while the
    // detector runs; it may toggle many times near the trip level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= low_voltage_ctrl_t'(5'(`RST_LOW_VOLTAGE_CONTROL));
        end else begin
            if (low_byte_wr && addr_hit(paddr, `OFS_LOW_VOLTAGE_CONTROL)) begin
                ctrl.detector_on       <= pwdata[`BIT_DETECTOR_ON];
                ctrl.trip_level_select <= pwdata[`BIT_TRIP_MSB:`BIT_TRIP_LSB];
            end
            ctrl.supply_low_flag <= detector_active & below_sync;
        end
    end

    // ======================================================================
    // interrupt delay: restarts on each rising flag, abandons if flag drops,
    // so a hovering supply only raises a request after a stable low period
    assign delay_done = delay_run && (delay_cnt == `DELAY_CNT_W'(`IRQ_ASSERT_DELAY_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_prev <= 1'b0;
            delay_run <= 1'b0;
            delay_cnt <= '0;
        end else begin
            flag_prev <= ctrl.supply_low_flag;
            if (!ctrl.supply_low_flag || !detector_active) begin
                delay_run <= 1'b0;
                delay_cnt <= '0;
            end else if (!flag_prev) begin
                delay_run <= 1'b1;
                delay_cnt <= '0;
            end else if (delay_done) begin
                delay_run <= 1'b0;
            end else if (delay_run) begin
                delay_cnt <= delay_cnt + `DELAY_CNT_W'(1);
            end
        end
    end

    // ======================================================================
    // shared interrupt register; hardware set wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_bits <= irq_bits_t'(2'(`RST_MULTI_SOURCE_IRQ_B));
        end else begin
            if (low_byte_wr && addr_hit(paddr, `OFS_MULTI_SOURCE_IRQ_B)) begin
                irq_bits.supply_low_irq_request <= pwdata[`BIT_IRQ_REQUEST];
                irq_bits.supply_low_irq_enable  <= pwdata[`BIT_IRQ_ENABLE];
            end
            if (delay_done && detector_active) begin
                irq_bits.supply_low_irq_request <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_irq_enable <= 1'b0;
        end else if (low_byte_wr && addr_hit(paddr, `OFS_GLOBAL_IRQ)) begin
            global_irq_enable <= pwdata[`BIT_GLOBAL_ENABLE];
        end
    end

    assign multi_source_irq_pending = irq_bits.supply_low_irq_request
                                    & irq_bits.supply_low_irq_enable;
    assign cpu_irq = multi_source_irq_pending & global_irq_enable;

    // ======================================================================
    // wake from idle: a request that rises while idle wakes the device; a
    // flag preset before idle shows no rise, so no wake follows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_prev  <= 1'b0;
            idle_wake <= 1'b0;
        end else begin
            irq_prev  <= irq_bits.supply_low_irq_request;
            idle_wake <= idle_mode & irq_bits.supply_low_irq_request & ~irq_prev;
        end
    end

    // ======================================================================
    // event status and mask, write one to clear, set beats clear
    assign evt_set[`BIT_EVT_FLAG_RISE]   = ctrl.supply_low_flag & ~flag_prev;
    assign evt_set[`BIT_EVT_IRQ_REQUEST] = delay_done & detector_active;
    assign evt_set[`BIT_EVT_WAKE]        = idle_wake;

    always_comb begin
        next_evt_status = evt_status;
        if (low_byte_wr && addr_hit(paddr, `OFS_EVENT_STATUS)) begin
            next_evt_status = evt_status & ~pwdata[`EVT_WIDTH-1:0];
        end
        next_evt_status = next_evt_status | evt_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status <= `RST_EVENTS;
        end else begin
            evt_status <= next_evt_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_mask <= `RST_EVENTS;
        end else if (low_byte_wr && addr_hit(paddr, `OFS_EVENT_MASK)) begin
            evt_mask <= pwdata[`EVT_WIDTH-1:0];
        end
    end

    assign event_irq = |(evt_status & evt_mask);

    // ======================================================================
    // read data, captured in setup phase; unused bits read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_en) begin
            prdata <= '0;
            if (addr_hit(paddr, `OFS_LOW_VOLTAGE_CONTROL)) begin
                prdata[`BIT_SUPPLY_LOW_FLAG]          <= ctrl.supply_low_flag;
                prdata[`BIT_DETECTOR_ON]              <= ctrl.detector_on;
                prdata[`BIT_TRIP_MSB:`BIT_TRIP_LSB]   <= ctrl.trip_level_select;
            end else if (addr_hit(paddr, `OFS_MULTI_SOURCE_IRQ_B)) begin
                prdata[`BIT_IRQ_REQUEST] <= irq_bits.supply_low_irq_request;
                prdata[`BIT_IRQ_ENABLE]  <= irq_bits.supply_low_irq_enable;
            end else if (addr_hit(paddr, `OFS_GLOBAL_IRQ)) begin
                prdata[`BIT_GLOBAL_ENABLE] <= global_irq_enable;
            end else if (addr_hit(paddr, `OFS_EVENT_STATUS)) begin
                prdata[`EVT_WIDTH-1:0] <= evt_status;
            end else if (addr_hit(paddr, `OFS_EVENT_MASK)) begin
                prdata[`EVT_WIDTH-1:0] <= evt_mask;
            end
        end
    end

endmodule

// *** supply_monitor_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing constants of the supply monitor.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef SUPPLY_MONITOR_REGS_SVH
`define SUPPLY_MONITOR_REGS_SVH

// ==========================================================================
// register byte addresses
`define OFS_LOW_VOLTAGE_CONTROL  12'h000
`define OFS_MULTI_SOURCE_IRQ_B   12'h004
`define OFS_GLOBAL_IRQ           12'h008
`define OFS_EVENT_STATUS         12'h00c
`define OFS_EVENT_MASK           12'h010

// ==========================================================================
// field positions
`define BIT_SUPPLY_LOW_FLAG      5
`define BIT_DETECTOR_ON          4
`define BIT_TRIP_MSB             2
`define BIT_TRIP_LSB             0
`define BIT_IRQ_REQUEST          6
`define BIT_IRQ_ENABLE           2
`define BIT_GLOBAL_ENABLE        0
`define BIT_EVT_FLAG_RISE        0
`define BIT_EVT_IRQ_REQUEST      1
`define BIT_EVT_WAKE             2
`define EVT_WIDTH                3

// ==========================================================================
// reset values
`define RST_LOW_VOLTAGE_CONTROL  8'h00
`define RST_MULTI_SOURCE_IRQ_B   8'h00
`define RST_EVENTS               3'h0

// ==========================================================================
// timing: printed figures are not given, so these are plain defaults
`define CLK_PERIOD_NS            50
`define IRQ_ASSERT_DELAY_NS      1000
`define IRQ_ASSERT_DELAY_CYC     ((`IRQ_ASSERT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DELAY_CNT_W              16

`endif

// *** supply_monitor_pkg.sv ***
/*
 * Types shared by the supply monitor files.
 * Assumes supply_monitor_regs.svh is compiled alongside.
 */
package supply_monitor_pkg;

    typedef struct packed {
        logic [2:0] trip_level_select;
        logic       detector_on;
        logic       supply_low_flag;
    } low_voltage_ctrl_t;

    typedef struct packed {
        logic supply_low_irq_request;
        logic supply_low_irq_enable;
    } irq_bits_t;

    typedef enum logic [2:0] {
        TRIP_1V8,
        TRIP_2V0,
        TRIP_2V4,
        TRIP_2V7,
        TRIP_3V0,
        TRIP_3V3,
        TRIP_3V6,
        TRIP_4V0
    } trip_level_t;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_IDLE,
        PWR_SLEEP
    } power_mode_t;

endpackage

// *** bit_sync.sv ***
/*
 * Two flip-flop synchroniser for one level.
 * Assumes the input may change at any time relative to pclk.
 */
`timescale 1ns/1ps
module bit_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic stage1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// *** supply_monitor_props.sv ***
/*
 * Port-level checker for the supply monitor.
 * Assumes one pclk domain with presetn asynchronous and active low.
 */
`timescale 1ns/1ps
`include "supply_monitor_regs.svh"
module supply_monitor_props (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        comparator_below,
    input  wire logic        idle_mode,
    input  wire logic        sleep_mode,
    input  wire logic        detector_power,
    input  wire logic [2:0]  trip_level_code,
    input  wire logic        multi_source_irq_pending,
    input  wire logic        cpu_irq,
    input  wire logic        idle_wake
);
    // slack of a few cycles below the nominal delay so pipeline skew never fires it
    localparam int MIN_RUN = 18;
    logic [2:0] below_d;
    logic [7:0] run;
    wire        wr = psel && penable && pwrite;

    // ========================================
    // comparator run length, aligned to the flag pipeline
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            below_d <= 3'h0;
            run     <= 8'h00;
        end else begin
            below_d <= {below_d[1:0], comparator_below};
            run     <= !below_d[2] ? 8'h00 : ((run == 8'hff) ? run : run + 8'h01);
        end
    end

    // ========================================
    // properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence ctrl_read;
        psel && penable && !pwrite && paddr == `OFS_LOW_VOLTAGE_CONTROL;
    endsequence
    sequence power_off_run;
        !detector_power [*4];
    endsequence

    sleep_off_a: assert property (sleep_mode |-> !detector_power)
        else $error("detector powered in sleep");
    rsvd_zero_a: assert property (ctrl_read |-> prdata[31:6] == 26'h0 && !prdata[3])
        else $error("unused control bits not zero");
    flag_off_a: assert property (power_off_run ##1 ctrl_read |-> !prdata[5])
        else $error("flag high with detector off");
    irq_delay_a: assert property ($rose(multi_source_irq_pending) && !$past(wr)
        |-> run >= MIN_RUN) else $error("request raised too early");
    cpu_gate_a: assert property (cpu_irq |-> multi_source_irq_pending)
        else $error("cpu interrupt without pending source");
    wake_pulse_a: assert property (idle_wake |-> $past(idle_mode) ##1 !idle_wake)
        else $error("wake pulse malformed");
    trip_write_a: assert property ($changed(trip_level_code)
        |-> $past(wr && paddr == `OFS_LOW_VOLTAGE_CONTROL)) else $error("trip changed alone");
    irq_reg_ok_a: assert property (psel && penable && paddr == `OFS_MULTI_SOURCE_IRQ_B
        |-> pready && !pslverr) else $error("shared irq register refused");
endmodule

bind supply_monitor supply_monitor_props u_supply_monitor_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .comparator_below, .idle_mode,
    .sleep_mode, .detector_power, .trip_level_code, .multi_source_irq_pending, .cpu_irq,
    .idle_wake);

// *** supply_partner.sv ***
/*
 * Behavioural analog comparator facing the supply monitor.
 * Assumes the supply is given in millivolts by the bench.
 */
`timescale 1ns/1ps
module supply_partner (
    input  wire logic [15:0] supply_mv,
    input  wire logic [2:0]  trip_level_code,
    input  wire logic        detector_power,
    output logic             comparator_below
);
    // ascending trip points in millivolts, 1.8V up to 4.0V
    localparam logic [15:0] TRIP_MV [8] = '{16'h0708, 16'h07d0, 16'h0960, 16'h0a8c,
        16'h0bb8, 16'h0ce4, 16'h0e10, 16'h0fa0};
    // an unpowered comparator drives low, it never holds its last answer
    assign comparator_below = detector_power && (supply_mv < TRIP_MV[trip_level_code]);
endmodule

// *** tb_top.sv ***
/*
 * Self-checking bench for the supply monitor over APB.
 * Assumes the comparator model of supply_partner and the regs header.
 */
`timescale 1ns/1ps
`include "supply_monitor_regs.svh"
module tb_top;
    localparam int SETTLE = 8;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        idle_mode = 1'b0, sleep_mode = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic [3:0]  pstrb = 4'hf;
    logic [15:0] supply_mv = 16'h1194;
    logic        pready, pslverr, err, comparator_below, detector_power;
    logic        multi_source_irq_pending, cpu_irq, idle_wake, event_irq;
    logic [2:0]  trip_level_code;
    int          fails = 0, n_tests = 0, n;

    supply_monitor u_supply_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .comparator_below, .idle_mode,
        .sleep_mode, .detector_power, .trip_level_code, .multi_source_irq_pending,
        .cpu_irq, .idle_wake, .event_irq);
    supply_partner u_supply_partner (.supply_mv, .trip_level_code, .detector_power,
        .comparator_below);

    initial begin
        forever #25 pclk = ~pclk;
    end

    // ========================================
    // shared tasks
    task automatic conclude;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask

    // one idle edge before each setup keeps every drive change a single assignment
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            if (++k > 16) begin
                fails++;
                conclude();
            end
        end while (pready !== 1'b1);
        {rdv, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask

    task automatic wait_hi(input logic sel);
        n = 0;
        while ((sel ? idle_wake : cpu_irq) !== 1'b1) begin
            @(negedge pclk);
            if (++n > 80) begin
                fails++;
                conclude();
            end
        end
    endtask

    // ========================================
    // scenarios
    task automatic regs_and_gate;
        xfer(`OFS_LOW_VOLTAGE_CONTROL, 0, 0); chk(rdv, 32'h0);
        xfer(`OFS_MULTI_SOURCE_IRQ_B, 0, 0); chk(rdv, 32'h0);
        xfer(`OFS_LOW_VOLTAGE_CONTROL, 1, 32'hff);
        xfer(`OFS_LOW_VOLTAGE_CONTROL, 0, 0); chk(rdv, 32'h17);
        xfer(`OFS_MULTI_SOURCE_IRQ_B, 1, 32'hff);
        xfer(`OFS_MULTI_SOURCE_IRQ_B, 0, 0); chk(rdv, 32'h44);
        @(negedge pclk); chk({multi_source_irq_pending, cpu_irq}, 2'b10);
        xfer(`OFS_GLOBAL_IRQ, 1, 1);
        @(negedge pclk); chk(cpu_irq, 1);
        xfer(12'h020, 0, 0); chk({err, rdv}, {1'b1, 32'h0});
        xfer(`OFS_MULTI_SOURCE_IRQ_B, 1, 0);
    endtask

    task automatic trip_levels;
        for (int c = 0; c < 8; c++) begin
            xfer(`OFS_LOW_VOLTAGE_CONTROL, 1, 32'h10 | c);
            supply_mv = u_supply_partner.TRIP_MV[c] - 16'h0032;
            repeat (SETTLE) @(posedge pclk);
            xfer(`OFS_LOW_VOLTAGE_CONTROL, 0, 0); chk(rdv, 32'h30 | c);
            chk(32'(trip_level_code), 32'(c));
            supply_mv = u_supply_partner.TRIP_MV[c] + 16'h0032;
            repeat (SETTLE) @(posedge pclk);
            xfer(`OFS_LOW_VOLTAGE_CONTROL, 0, 0); chk(rdv, 32'h10 | c);
        end
    endtask

    task automatic delayed_irq;
        xfer(`OFS_LOW_VOLTAGE_CONTROL, 1, 32'h17);
        xfer(`OFS_MULTI_SOURCE_IRQ_B, 1, 32'h04);
        xfer(`OFS_EVENT_MASK, 1, 32'h2);
        xfer(`OFS_EVENT_STATUS, 1, 32'h7);
        supply_mv = 16'h0bb8;
        wait_hi(0);
        chk(n >= 20 && n < 40, 1);
        chk(event_irq, 1);
        xfer(`OFS_EVENT_STATUS, 1, 32'h2);
        @(negedge pclk); chk(event_irq, 0);
        supply_mv = 16'h1194;
        xfer(`OFS_MULTI_SOURCE_IRQ_B, 1, 32'h04);
    endtask

    // a supply hovering at the trip point must restart the delay every time
    task automatic hovering;
        xfer(`OFS_EVENT_STATUS, 1, 32'h7);
        xfer(`OFS_EVENT_STATUS, 0, 0); chk(rdv, 32'h0);
        for (int i = 0; i < 6; i++) begin
            supply_mv = 16'h0bb8;
            repeat (10) @(posedge pclk);
            supply_mv = 16'h1194;
            repeat (4) @(posedge pclk);
        end
        @(negedge pclk); chk(multi_source_irq_pending, 0);
        xfer(`OFS_EVENT_STATUS, 0, 0); chk(rdv, 32'h1);
    endtask

    task automatic idle_wakeup;
        int k;
        @(posedge pclk);
        idle_mode <= 1'b1;
        supply_mv = 16'h0bb8;
        wait_hi(1); chk(idle_wake, 1);
        xfer(`OFS_MULTI_SOURCE_IRQ_B, 0, 0); chk(rdv, 32'h44);
        supply_mv = 16'h1194;
        xfer(`OFS_MULTI_SOURCE_IRQ_B, 1, 32'h44);
        supply_mv = 16'h0bb8;
        k = 0;
        repeat (40) begin
            @(negedge pclk);
            k += idle_wake;
        end
        chk(k, 0);
        @(posedge pclk);
        idle_mode <= 1'b0;
        xfer(`OFS_MULTI_SOURCE_IRQ_B, 1, 32'h04);
    endtask

    task automatic sleep_off;
        @(posedge pclk);
        sleep_mode <= 1'b1;
        repeat (30) @(posedge pclk);
        @(negedge pclk); chk(detector_power, 0);
        xfer(`OFS_LOW_VOLTAGE_CONTROL, 0, 0); chk(rdv, 32'h17);
        xfer(`OFS_MULTI_SOURCE_IRQ_B, 0, 0); chk(rdv, 32'h04);
        @(posedge pclk);
        sleep_mode <= 1'b0;
        @(negedge pclk); chk(detector_power, 1);
        xfer(`OFS_LOW_VOLTAGE_CONTROL, 1, 32'h07);
        @(negedge pclk); chk(detector_power, 0);
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        regs_and_gate();
        trip_levels();
        delayed_irq();
        hovering();
        idle_wakeup();
        sleep_off();
        conclude();
    end
endmodule
